// file: dv/ppc_partner.sv
// Host model for slave mode: writes and reads bytes through the port pins.
// Assumes active-low select and strobes, the polarity left by reset.
`timescale 1ns/1ps
module ppc_partner (
	input wire logic clock_in,
	output logic [7:0] data_out,
	output logic wr_n_out,
	output logic rd_n_out,
	output logic sel_n_out
);
	// Idle: strobes off, bus released shows inverse of last byte
	initial begin
		wr_n_out = 1'b1;
		rd_n_out = 1'b1;
		sel_n_out = 1'b1;
		data_out = 8'hff;
	end
	// Strobe spans six cycles so the two-stage sync sees it
	task automatic host_write(input logic [7:0] d);
		@(posedge clock_in);
		sel_n_out <= 1'b0;
		data_out <= d;
		wr_n_out <= 1'b0;
		repeat (6) @(posedge clock_in);
		wr_n_out <= 1'b1;
		repeat (3) @(posedge clock_in);
		sel_n_out <= 1'b1;
		data_out <= ~d;
		repeat (4) @(posedge clock_in);
	endtask : host_write
	// Read strobe long enough for the sync; select outlasts it so the end is seen
	task automatic host_read;
		@(posedge clock_in);
		sel_n_out <= 1'b0;
		rd_n_out <= 1'b0;
		repeat (6) @(posedge clock_in);
		rd_n_out <= 1'b1;
		repeat (3) @(posedge clock_in);
		sel_n_out <= 1'b1;
		repeat (4) @(posedge clock_in);
	endtask : host_read
endmodule : ppc_partner

// file: dv/ppc_port_tb_top.sv
// Self-checking bench for ppc_port: registers, master timing, slave input.
// Assumes the partner model drives the slave pins.
`timescale 1ns/1ps
module ppc_port_tb_top;
	import ppc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] ra = 4'h0;
	logic [7:0] wd = 8'h00;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [7:0] rdat;
	logic [7:0] pd;
	logic [7:0] pdo;
	logic wr_n, rd_n, sel_n;
	logic irq, stall, wstb;
	int n_errors = 0;
	int samples_checked = 0;
	logic [7:0] v, t, e;
	always #5 clk = ~clk;
	ppc_partner p (.clock_in(clk), .data_out(pd), .wr_n_out(wr_n),
		.rd_n_out(rd_n), .sel_n_out(sel_n));
	ppc_port dut (.clock_in(clk), .rst_n_in(rst_n), .reg_addr_in(ra),
		.reg_wdata_in(wd), .reg_write_in(we), .reg_read_in(re),
		.reg_rdata_out(rdat), .port_address_pins_out(),
		.port_address_pins_oe_n_out(), .port_data_pins_in(pd),
		.port_data_pins_out(pdo), .port_data_pins_oe_n_out(),
		.read_strobe_out(), .write_strobe_out(wstb), .byte_enable_out(),
		.strobe_oe_n_out(), .slave_read_in(rd_n), .slave_write_in(wr_n),
		.slave_select_in(sel_n), .slave_addr_in(2'b00), .irq_out(irq),
		.cpu_stall_out(stall));
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
		samples_checked++;
		if (s !== x) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		ra <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdat;
	endtask : rd
	// Count cycles a level stays high after a start, bounded
	task automatic cnt(input bit use_irq, output logic [7:0] n);
		n = 8'h00;
		repeat (80) begin
			#1 n += use_irq ? irq : stall;
			@(posedge clk);
		end
	endtask : cnt
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict
	initial begin
		#200us;
		n_errors++;
		give_verdict();
	end
	initial begin
		void'($urandom(44385));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, unmapped index reads zero
		for (int i = 0; i < 9; i++) begin
			rd(i == 8 ? 4'he : 4'(i), v);
			chk("reset", v, i == 7 ? 8'h8f : 8'h00);
		end
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			e = 8'($urandom);
			wr(4'(1 + i % 4 + (i % 4 > 0)), e);
			rd(4'(1 + i % 4 + (i % 4 > 0)), v);
			chk("rw", v, e);
		end
		wr(4'h2, 8'hfc);
		rd(4'h2, v);
		chk("busy ro", v, 8'h7c);
		wr(4'h1, 8'h00);
		$display("test regs done");
		// Master mode 2, stall mode: stall length is the wait sum plus three, one cycle at zero strobe wait
		wr(4'h2, 8'h4a);
		wr(4'h0, 8'h80);
		repeat (3) @(posedge clk);
		#1 chk("wr idle", {7'h0, wstb}, 8'h01);
		for (int k = 0; k < 6; k++) begin
			t = 8'($urandom);
			if (k == 0)
				t &= 8'hc3;
			wr(4'h3, t);
			wr(4'h8, 8'($urandom));
			cnt(1'b0, v);
			e = t[5:2] == 4'h0 ? 8'h01 : 8'(t[7:6] + t[5:2] + t[1:0] + 3);
			chk("busy len", v, e);
		end
		// Increment mode was up: six single-byte transfers
		rd(4'hc, v);
		chk("addr inc", v, 8'h06);
		wr(4'h2, 8'h22);
		wr(4'h8, 8'h5a);
		cnt(1'b1, v);
		chk("irq", v, 8'h01);
		$display("test master done");
		// Legacy slave: host writes set full, overflow, reads clear
		wr(4'h2, 8'h00);
		e = 8'($urandom);
		p.host_write(e);
		rd(4'h6, v);
		chk("in full", v, 8'h01);
		rd(4'h8, v);
		chk("in data", v, e);
		rd(4'h6, v);
		chk("in clr", v, 8'h00);
		p.host_write(8'h11);
		p.host_write(8'h22);
		rd(4'h6, v);
		chk("ovf", v & 8'h7f, 8'h41);
		// Host reads slot 0: first drains it, second underflows
		wr(4'h8, e);
		rd(4'h7, v);
		chk("out full", v, 8'h0e);
		p.host_read();
		chk("out data", pdo, e);
		rd(4'h7, v);
		chk("out empty", v, 8'h8f);
		p.host_read();
		rd(4'h7, v);
		chk("unf", v, 8'hcf);
		wr(4'h7, 8'h00);
		rd(4'h7, v);
		chk("unf clr", v, 8'h8f);
		$display("test slave done");
		give_verdict();
	end
endmodule : ppc_port_tb_top

// file: logic/ppc_master_seq.sv
// Master transfer sequencer: address, setup, strobe and hold phases per byte.
// Assumes the caller only pulses start while busy is low.
`timescale 1ns/1ps
module ppc_master_seq
	import ppc_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic wide_in,
	input wire logic [1:0] mux_in,
	input wire ppc_timing_t timing_in,
	output ppc_phase_t phase_out,
	output logic byte_out,
	output logic busy_out,
	output logic step_out,
	output logic done_out
);

	ppc_seq_state_t q;
	ppc_seq_state_t d;
	logic [3:0] setup_n;
	logic [3:0] hold_n;
	logic last;
	ppc_seq_state_t enter_data;
	ppc_seq_state_t enter_first;

	// Zero strobe wait drops the setup and hold stretches entirely
	always_comb begin
		setup_n = (timing_in.strobe == 4'h0) ? 4'h0 : {2'b00, timing_in.setup};
		hold_n = (timing_in.strobe == 4'h0) ? 4'h0 : {2'b00, timing_in.hold};
		last = (q.cnt == 4'h0);
		enter_data = '{phase: PH_SETUP, cnt: setup_n, byte_idx: q.byte_idx};
		if (timing_in.strobe == 4'h0) begin
			enter_data = '{phase: PH_STROBE, cnt: 4'h0, byte_idx: q.byte_idx};
		end
		enter_first = enter_data;
		if (mux_in != MUX_NONE) begin
			enter_first = '{phase: PH_ADDR_LOW, cnt: setup_n, byte_idx: q.byte_idx};
		end
	end

	// Each phase lasts its count plus one cycle
	always_comb begin
		d = q;
		step_out = 1'b0;
		done_out = 1'b0;
		case (q.phase)
			PH_IDLE: begin
				if (start_in) begin
					d = enter_first;
					d.byte_idx = 1'b0;
				end
			end
			PH_ADDR_LOW: begin
				if (!last) begin
					d.cnt = q.cnt - 4'h1;
				end else if (mux_in == MUX_FULL) begin
					d = '{phase: PH_ADDR_HIGH, cnt: setup_n, byte_idx: q.byte_idx};
				end else begin
					d = enter_data;
				end
			end
			PH_ADDR_HIGH: begin
				d = last ? enter_data : '{phase: PH_ADDR_HIGH, cnt: q.cnt - 4'h1, byte_idx: q.byte_idx};
			end
			PH_SETUP: begin
				d = last ? '{phase: PH_STROBE, cnt: timing_in.strobe, byte_idx: q.byte_idx} :
					'{phase: PH_SETUP, cnt: q.cnt - 4'h1, byte_idx: q.byte_idx};
			end
			PH_STROBE, PH_HOLD: begin
				if (!last) begin
					d.cnt = q.cnt - 4'h1;
				end else if (q.phase == PH_STROBE && timing_in.strobe != 4'h0) begin
					d = '{phase: PH_HOLD, cnt: hold_n, byte_idx: q.byte_idx};
				end else begin
					step_out = 1'b1;
					if (wide_in && !q.byte_idx) begin
						d = enter_first;
						d.byte_idx = 1'b1;
					end else begin
						d = '{phase: PH_IDLE, cnt: 4'h0, byte_idx: 1'b0};
						done_out = 1'b1;
					end
				end
			end
			default: begin
				d = '{phase: PH_IDLE, cnt: 4'h0, byte_idx: 1'b0};
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '{phase: PH_IDLE, cnt: 4'h0, byte_idx: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign phase_out = q.phase;
	assign byte_out = q.byte_idx;
	assign busy_out = (q.phase != PH_IDLE);

endmodule : ppc_master_seq

// file: logic/ppc_pkg.sv
// Shared constants and types for the parallel port configuration block.
// Assumes one 100 MHz clock where one clock period is one instruction cycle.
package ppc_pkg;

	// Register indices on the 4-bit register port
	localparam logic [3:0] REG_CTRL_HIGH = 4'h0;
	localparam logic [3:0] REG_CTRL_LOW = 4'h1;
	localparam logic [3:0] REG_MODE_HIGH = 4'h2;
	localparam logic [3:0] REG_WAIT_CFG = 4'h3;
	localparam logic [3:0] REG_PEN_HIGH = 4'h4;
	localparam logic [3:0] REG_PEN_LOW = 4'h5;
	localparam logic [3:0] REG_IN_STAT = 4'h6;
	localparam logic [3:0] REG_OUT_STAT = 4'h7;
	localparam logic [3:0] REG_SLOT_BASE = 4'h8;
	localparam logic [3:0] REG_ADDR_LOW = 4'hc;
	localparam logic [3:0] REG_ADDR_HIGH = 4'hd;

	// Field positions
	localparam int CTL_PORT_EN = 7;
	localparam int CTL_MUX_LSB = 3;
	localparam int CTL_CSF_LSB = 6;
	localparam int CTL_LATCH_POL = 5;
	localparam int CTL_SEL2_POL = 4;
	localparam int CTL_SEL1_POL = 3;
	localparam int CTL_BE_POL = 2;
	localparam int CTL_WR_POL = 1;
	localparam int CTL_RD_POL = 0;
	localparam int MOD_BUSY = 7;
	localparam int MOD_IRQ_LSB = 5;
	localparam int MOD_INC_LSB = 3;
	localparam int MOD_WIDE = 2;
	localparam int MOD_MODE_LSB = 0;
	localparam int WT_SETUP_LSB = 6;
	localparam int WT_STROBE_LSB = 2;
	localparam int WT_HOLD_LSB = 0;
	localparam int ST_ALL = 7;
	localparam int ST_ERR = 6;

	// Reset values
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [3:0] OUT_EMPTY_RESET = 4'hf;

	// Field codes
	localparam logic [1:0] CSF_BOTH = 2'b10;
	localparam logic [1:0] CSF_TWO = 2'b01;
	localparam logic [1:0] IRQ_NONE = 2'b00;
	localparam logic [1:0] IRQ_CYCLE = 2'b01;
	localparam logic [1:0] IRQ_STALL = 2'b10;
	localparam logic [1:0] IRQ_SLOT3 = 2'b11;
	localparam logic [1:0] INC_UP = 2'b01;
	localparam logic [1:0] INC_DOWN = 2'b10;
	localparam logic [1:0] INC_BUFFER = 2'b11;
	localparam logic [1:0] MUX_NONE = 2'b00;
	localparam logic [1:0] MUX_FULL = 2'b10;
	localparam logic [1:0] SLOT_LAST = 2'b11;

	typedef enum logic [1:0] {
		MODE_LEGACY = 2'b00,
		MODE_ADDR_SLAVE = 2'b01,
		MODE_MASTER2 = 2'b10,
		MODE_MASTER1 = 2'b11
	} ppc_mode_t;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_ADDR_LOW = 3'b001,
		PH_ADDR_HIGH = 3'b010,
		PH_SETUP = 3'b011,
		PH_STROBE = 3'b100,
		PH_HOLD = 3'b101
	} ppc_phase_t;

	typedef struct packed {
		logic [1:0] setup;
		logic [3:0] strobe;
		logic [1:0] hold;
	} ppc_timing_t;

	typedef struct packed {
		ppc_phase_t phase;
		logic [3:0] cnt;
		logic byte_idx;
	} ppc_seq_state_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic cs;
		logic [1:0] addr;
		logic [7:0] data;
	} ppc_slave_pins_t;

	typedef struct packed {
		logic [7:0] ctrl_high;
		logic [7:0] ctrl_low;
		logic [7:0] mode_high;
		logic [7:0] wait_cfg;
		logic [15:0] pin_en;
		logic [15:0] addr;
		logic [3:0][7:0] in_slot;
		logic [3:0][7:0] out_slot;
		logic [3:0] in_full;
		logic [3:0] out_empty;
		logic in_ovf;
		logic out_unf;
		logic [1:0] in_ptr;
		logic [1:0] out_ptr;
		logic master_read;
		logic slave_wr_prev;
		logic slave_rd_prev;
		logic irq;
		logic [7:0] rdata;
		logic [15:0] pin_addr;
		logic [7:0] pin_data;
		logic pin_data_oe_n;
		logic pin_rd;
		logic pin_wr;
		logic pin_be;
	} ppc_state_t;

endpackage : ppc_pkg

// file: logic/ppc_port.sv
// Parallel port configuration, timing and buffer status block (top level).
// Assumes a synchronous register port and asynchronous external pins.
`timescale 1ns/1ps
module ppc_port
	import ppc_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	output logic [15:0] port_address_pins_out,
	output logic [15:0] port_address_pins_oe_n_out,
	input wire logic [7:0] port_data_pins_in,
	output logic [7:0] port_data_pins_out,
	output logic [7:0] port_data_pins_oe_n_out,
	output logic read_strobe_out,
	output logic write_strobe_out,
	output logic byte_enable_out,
	output logic strobe_oe_n_out,
	input wire logic slave_read_in,
	input wire logic slave_write_in,
	input wire logic slave_select_in,
	input wire logic [1:0] slave_addr_in,
	output logic irq_out,
	output logic cpu_stall_out
);

	localparam ppc_state_t ST_RESET = '{out_empty: OUT_EMPTY_RESET, default: '0};

	ppc_state_t q;
	ppc_state_t d;
	ppc_slave_pins_t pins_s;
	logic [$bits(ppc_slave_pins_t)-1:0] pins_raw;
	logic port_en;
	logic [1:0] mux;
	logic [1:0] csf;
	ppc_mode_t mode;
	logic [1:0] irq_mode;
	logic [1:0] inc_mode;
	logic wide;
	logic master;
	logic slave_en;
	ppc_timing_t timing;
	logic cs_act;
	logic wr_act;
	logic rd_act;
	logic wr_end;
	logic rd_end;
	logic [1:0] in_sel;
	logic [1:0] out_sel;
	logic slot_hit;
	logic [1:0] cpu_slot;
	logic seq_start;
	logic start_read;
	ppc_phase_t phase;
	logic seq_byte;
	logic busy;
	logic seq_step;
	logic seq_done;
	logic [14:0] addr_cnt;
	logic buffered;

	// Pin inputs cross into the clock domain as one bundle
	ppc_sync2 #(
		.WIDTH($bits(ppc_slave_pins_t))
	) u_sync (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.async_in({slave_read_in, slave_write_in, slave_select_in, slave_addr_in,
			port_data_pins_in}),
		.sync_out(pins_raw)
	);
	assign pins_s = ppc_slave_pins_t'(pins_raw);

	ppc_master_seq u_seq (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.start_in(seq_start),
		.wide_in(wide),
		.mux_in(mux),
		.timing_in(timing),
		.phase_out(phase),
		.byte_out(seq_byte),
		.busy_out(busy),
		.step_out(seq_step),
		.done_out(seq_done)
	);

	// Field decode from the configuration registers
	assign port_en = q.ctrl_high[CTL_PORT_EN];
	assign mux = q.ctrl_high[CTL_MUX_LSB +: 2];
	assign csf = q.ctrl_low[CTL_CSF_LSB +: 2];
	assign mode = ppc_mode_t'(q.mode_high[MOD_MODE_LSB +: 2]);
	assign irq_mode = q.mode_high[MOD_IRQ_LSB +: 2];
	assign inc_mode = q.mode_high[MOD_INC_LSB +: 2];
	assign wide = q.mode_high[MOD_WIDE];
	assign master = port_en & mode[1];
	assign slave_en = port_en & !mode[1];
	assign timing = '{setup: q.wait_cfg[WT_SETUP_LSB +: 2], strobe: q.wait_cfg[WT_STROBE_LSB +: 4],
		hold: q.wait_cfg[WT_HOLD_LSB +: 2]};
	assign buffered = (mode == MODE_LEGACY) && (inc_mode == INC_BUFFER);

	// Slave strobes qualified by select and their polarity bits
	assign cs_act = slave_en & (pins_s.cs == q.ctrl_low[CTL_SEL1_POL]);
	assign wr_act = cs_act & (pins_s.wr == q.ctrl_low[CTL_WR_POL]);
	assign rd_act = cs_act & (pins_s.rd == q.ctrl_low[CTL_RD_POL]);
	assign wr_end = q.slave_wr_prev & !wr_act;
	assign rd_end = q.slave_rd_prev & !rd_act;
	assign in_sel = (mode == MODE_ADDR_SLAVE) ? pins_s.addr : (buffered ? q.in_ptr : 2'b00);
	assign out_sel = (mode == MODE_ADDR_SLAVE) ? pins_s.addr : (buffered ? q.out_ptr : 2'b00);

	// Master transfers start from a data access while idle
	assign slot_hit = (reg_addr_in[3:2] == REG_SLOT_BASE[3:2]);
	assign cpu_slot = reg_addr_in[1:0];
	assign start_read = master & !busy & reg_read_in & slot_hit & (cpu_slot == 2'b00);
	assign seq_start = start_read | (master & !busy & reg_write_in & slot_hit &
		(cpu_slot == {1'b0, wide}));
	assign addr_cnt = {q.addr[15], q.addr[13:0]};

	// Next state: software access first, then hardware events so a set wins
	always_comb begin
		d = q;
		d.irq = 1'b0;
		d.rdata = 8'h00;
		if (reg_write_in) begin
			case (reg_addr_in)
				REG_CTRL_HIGH: d.ctrl_high = reg_wdata_in;
				REG_CTRL_LOW: d.ctrl_low = reg_wdata_in;
				REG_MODE_HIGH: d.mode_high = {1'b0, reg_wdata_in[6:0]};
				REG_WAIT_CFG: d.wait_cfg = reg_wdata_in;
				REG_PEN_HIGH: d.pin_en[15:8] = reg_wdata_in;
				REG_PEN_LOW: d.pin_en[7:0] = reg_wdata_in;
				REG_IN_STAT: d.in_ovf = q.in_ovf & reg_wdata_in[ST_ERR];
				REG_OUT_STAT: d.out_unf = q.out_unf & reg_wdata_in[ST_ERR];
				REG_ADDR_LOW: d.addr[7:0] = reg_wdata_in;
				REG_ADDR_HIGH: d.addr[15:8] = reg_wdata_in;
				default: begin
					if (slot_hit) begin
						d.out_slot[cpu_slot] = reg_wdata_in;
						d.out_empty[cpu_slot] = 1'b0;
					end
				end
			endcase
		end
		if (reg_read_in) begin
			case (reg_addr_in)
				REG_CTRL_HIGH: d.rdata = q.ctrl_high;
				REG_CTRL_LOW: d.rdata = q.ctrl_low;
				REG_MODE_HIGH: d.rdata = {busy, q.mode_high[6:0]};
				REG_WAIT_CFG: d.rdata = q.wait_cfg;
				REG_PEN_HIGH: d.rdata = q.pin_en[15:8];
				REG_PEN_LOW: d.rdata = q.pin_en[7:0];
				REG_IN_STAT: d.rdata = {&q.in_full, q.in_ovf, 2'b00, q.in_full};
				REG_OUT_STAT: d.rdata = {&q.out_empty, q.out_unf, 2'b00, q.out_empty};
				REG_ADDR_LOW: d.rdata = q.addr[7:0];
				REG_ADDR_HIGH: d.rdata = q.addr[15:8];
				default: begin
					if (slot_hit) begin
						d.rdata = q.in_slot[cpu_slot];
						d.in_full[cpu_slot] = 1'b0;
					end
				end
			endcase
		end
		if (seq_start) begin
			d.master_read = start_read;
		end
		// Master byte done: capture read data, advance address in up or down increment mode
		if (seq_step) begin
			if (q.master_read) begin
				d.in_slot[{1'b0, seq_byte}] = pins_s.data;
				d.in_full[{1'b0, seq_byte}] = 1'b1;
			end else begin
				d.out_empty[{1'b0, seq_byte}] = 1'b1;
			end
			if (inc_mode == INC_UP) begin
				{d.addr[15], d.addr[13:0]} = addr_cnt + 15'h0001;
			end else if (inc_mode == INC_DOWN) begin
				{d.addr[15], d.addr[13:0]} = addr_cnt - 15'h0001;
			end
		end
		// Slave write ends: store or flag overflow
		d.slave_wr_prev = wr_act;
		d.slave_rd_prev = rd_act;
		if (wr_end) begin
			if (q.in_full[in_sel]) begin
				d.in_ovf = 1'b1;
			end else begin
				d.in_slot[in_sel] = pins_s.data;
				d.in_full[in_sel] = 1'b1;
			end
			if (buffered) begin
				d.in_ptr = q.in_ptr + 2'b01;
			end
		end
		// Slave read ends: mark the slot drained or flag underflow
		if (rd_end) begin
			if (q.out_empty[out_sel]) begin
				d.out_unf = 1'b1;
			end
			d.out_empty[out_sel] = 1'b1;
			if (buffered) begin
				d.out_ptr = q.out_ptr + 2'b01;
			end
		end
		// Interrupt pulse per the selected request mode
		if (irq_mode == IRQ_CYCLE) begin
			d.irq = seq_done | wr_end | rd_end;
		end else if (irq_mode == IRQ_SLOT3 && (buffered || mode == MODE_ADDR_SLAVE)) begin
			d.irq = (wr_end & (in_sel == SLOT_LAST)) | (rd_end & (out_sel == SLOT_LAST));
		end
		// Address pins: selects on 15:14, latch strobes on 1:0 when multiplexed
		d.pin_addr = q.addr;
		if (csf == CSF_BOTH || csf == CSF_TWO) begin
			d.pin_addr[15] = q.addr[15] ~^ q.ctrl_low[CTL_SEL2_POL];
		end
		if (csf == CSF_BOTH) begin
			d.pin_addr[14] = q.addr[14] ~^ q.ctrl_low[CTL_SEL1_POL];
		end
		if (mux != MUX_NONE) begin
			d.pin_addr[0] = (phase == PH_ADDR_LOW) ~^ q.ctrl_low[CTL_LATCH_POL];
			d.pin_addr[1] = (phase == PH_ADDR_HIGH) ~^ q.ctrl_low[CTL_LATCH_POL];
		end
		// Data pins: address byte, write data, or slave read data
		case (phase)
			PH_ADDR_LOW: d.pin_data = q.addr[7:0];
			PH_ADDR_HIGH: d.pin_data = q.addr[15:8];
			PH_IDLE: d.pin_data = q.out_slot[out_sel];
			default: d.pin_data = q.out_slot[{1'b0, seq_byte}];
		endcase
		d.pin_data_oe_n = !((master & busy & (!q.master_read | phase == PH_ADDR_LOW |
			phase == PH_ADDR_HIGH)) | rd_act);
		// Strobe pins: polarity bit meaning depends on the mode
		if (mode == MODE_MASTER1) begin
			d.pin_rd = (busy & q.master_read) ~^ q.ctrl_low[CTL_RD_POL];
			d.pin_wr = (phase == PH_STROBE) ~^ q.ctrl_low[CTL_WR_POL];
		end else begin
			d.pin_rd = (phase == PH_STROBE & q.master_read) ~^ q.ctrl_low[CTL_RD_POL];
			d.pin_wr = (phase == PH_STROBE & !q.master_read) ~^ q.ctrl_low[CTL_WR_POL];
		end
		d.pin_be = (busy & wide) ~^ q.ctrl_low[CTL_BE_POL];
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= ST_RESET;
		end else begin
			q <= d;
		end
	end

	// Outputs; address and strobe enables are low only in master mode, data enables also during a slave read
	assign reg_rdata_out = q.rdata;
	assign port_address_pins_out = q.pin_addr;
	assign port_address_pins_oe_n_out = ~(q.pin_en & {16{master}});
	assign port_data_pins_out = q.pin_data;
	assign port_data_pins_oe_n_out = {8{q.pin_data_oe_n}};
	assign read_strobe_out = q.pin_rd;
	assign write_strobe_out = q.pin_wr;
	assign byte_enable_out = q.pin_be;
	assign strobe_oe_n_out = !master;
	assign irq_out = q.irq;
	assign cpu_stall_out = busy & (irq_mode == IRQ_STALL);

	a_start_busy: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		seq_start |=> busy)
		else $error("Transfer start did not raise busy");

	a_single_cycle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(seq_start && timing.strobe == 4'h0 && mux == MUX_NONE && !wide && !reg_write_in)
		|=> seq_step && seq_done ##1 !busy)
		else $error("Zero strobe wait did not give a single cycle transfer");

	a_setup_ignored: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(phase == PH_SETUP) |-> (timing.strobe != 4'h0))
		else $error("Setup phase entered with zero strobe wait");

	a_cycle_irq: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(seq_done && irq_mode == IRQ_CYCLE) |=> irq_out)
		else $error("No interrupt at end of master cycle");

	a_no_irq: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(irq_mode == IRQ_NONE) ##1 (irq_mode == IRQ_NONE) |-> !irq_out)
		else $error("Interrupt raised in no-interrupt mode");

	a_addr_up: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(seq_step && inc_mode == INC_UP && !reg_write_in)
		|=> q.addr[13:0] == $past(q.addr[13:0]) + 14'h0001)
		else $error("Address did not increment after a cycle");

	a_overflow_set: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(wr_end && q.in_full[in_sel]) |=> q.in_ovf && $stable(q.in_full))
		else $error("Write to full slot did not flag overflow");

	a_empty_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(reg_write_in && reg_addr_in == REG_SLOT_BASE && !(rd_end && out_sel == 2'b00) && !seq_step)
		|=> !q.out_empty[0])
		else $error("Slot write did not clear empty flag");

	a_sel_polarity: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(csf == CSF_BOTH && !reg_write_in)
		|=> port_address_pins_out[14] == ($past(q.addr[14]) ~^ q.ctrl_low[CTL_SEL1_POL]))
		else $error("Select one pin level wrong for its polarity");

	a_port_off: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!port_en |-> (&port_address_pins_oe_n_out) && strobe_oe_n_out && !busy ##1 !seq_start)
		else $error("Pins driven while port disabled");

	// Hardware set wins, so a same-cycle status write must not hide it
	a_underflow_set: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(rd_end && q.out_empty[out_sel]) |=> q.out_unf)
		else $error("Read of an empty slot did not flag underflow");

	a_busy_read: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(reg_read_in && reg_addr_in == REG_MODE_HIGH) |=> reg_rdata_out[MOD_BUSY] == $past(busy))
		else $error("Busy bit read back wrong");

endmodule : ppc_port

// file: logic/ppc_sync2.sv
// Two-stage synchroniser for a bundle of asynchronous pin inputs.
// Assumes each bit is independent; multi-bit words must be stable around strobes.
`timescale 1ns/1ps
module ppc_sync2 #(
	parameter int WIDTH = 8
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [1:0][WIDTH-1:0] stage_q;
	logic [1:0][WIDTH-1:0] stage_d;

	// Stage 0 feeds only stage 1, never any logic
	always_comb begin
		stage_d[0] = async_in;
		stage_d[1] = stage_q[0];
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stage_q <= '0;
		end else begin
			stage_q <= stage_d;
		end
	end

	assign sync_out = stage_q[1];

endmodule : ppc_sync2
